// >>> design/sttx_top.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module sttx_top (
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire sttx_pkg::sttx_bus_req_s bus_req,
  output logic [31:0]                  rd_data,
  input  wire logic                    baud_tick,
  output logic                         diagnostic_serial_out
);
  import sttx_pkg::*;

  typedef struct packed {
    sttx_phase_e     phase;
    logic            en;
    logic [2:0]      cnt;
    logic [2:0][15:0] data;
    logic [2:0]      filled;
    logic [2:0]      idx;
    logic [31:0]     rd_data;
  } sttx_top_state_s;

  sttx_top_state_s q, d;

  logic        key_commit;
  logic [15:0] key_val;
  logic        fr_busy;
  logic        fr_take;
  logic        fr_valid;
  logic [7:0]  fr_byte;
  logic [2:0]  nbytes;
  logic        flags_ok;
  logic [15:0] cur_word;
  logic [3:0]  state_field;
  logic [31:0] ctrl_read;

  sttx_key_guard u_key_guard (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .bus_req    (bus_req),
    .key_commit (key_commit),
    .key_val    (key_val)
  );

  sttx_framer u_framer (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .baud_tick  (baud_tick),
    .abort      (key_commit),
    .load_valid (fr_valid),
    .load_byte  (fr_byte),
    .busy       (fr_busy),
    .take       (fr_take),
    .serial_out (diagnostic_serial_out)
  );

  // Codes above the largest count are treated as six bytes.
  assign nbytes = (q.cnt > STTX_CNT_MAX) ? STTX_BYTES_MAX : q.cnt + 3'h1;

  // Each data register that holds at least one selected byte must be written.
  always_comb begin
    flags_ok = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (3'(2 * i) < nbytes && !q.filled[i]) begin
        flags_ok = 1'b0;
      end
    end
  end

  // Bytes go out in ascending order, low half of each register first.
  assign cur_word = (q.idx[2:1] > 2'h2) ? STTX_DATA_RESET : q.data[q.idx[2:1]];
  assign fr_byte  = q.idx[0] ? cur_word[15:8] : cur_word[7:0];
  assign fr_valid = q.phase == STTX_SEND && q.en && q.idx < nbytes;

  // The state field is one more than the number of bytes taken while sending, and zero when idle.
  assign state_field = (q.phase == STTX_SEND) ? {1'b0, q.idx} + 4'h1 : 4'h0;

  always_comb begin
    ctrl_read                             = 32'h0;
    ctrl_read[STTX_EN_BIT]                = q.en;
    ctrl_read[STTX_CNT_MSB:STTX_CNT_LSB]  = q.cnt;
    ctrl_read[STTX_STATE_MSB:STTX_STATE_LSB] = state_field;
  end

  always_comb begin
    d         = q;
    d.rd_data = 32'h0;

    unique case (q.phase)
      STTX_IDLE: begin
        if (q.en && flags_ok) begin
          d.phase = STTX_SEND;
          d.idx   = 3'h0;
        end
      end
      STTX_SEND: begin
        if (fr_take) begin
          d.idx = q.idx + 3'h1;
        end
        if (q.idx == nbytes && !fr_busy && !fr_take) begin
          d.phase  = STTX_IDLE;
          d.filled = 3'h0;
        end
      end
    endcase

    // A committed control write aborts any frame and restarts the fill count.
    if (key_commit) begin
      d.phase  = STTX_IDLE;
      d.idx    = 3'h0;
      d.filled = 3'h0;
      if (key_val[STTX_RST_BIT]) begin
        d.en  = 1'b0;
        d.cnt = 3'h0;
      end else begin
        d.en  = key_val[STTX_EN_BIT];
        d.cnt = key_val[STTX_CNT_MSB:STTX_CNT_LSB];
      end
    end

    // A data write sets its fill flag, winning over a completion clear.
    if (bus_req.wr) begin
      for (int i = 0; i < 3; i++) begin
        if (bus_req.addr == STTX_DATA_OFF[i]) begin
          d.data[i]   = bus_req.wdata[15:0];
          d.filled[i] = 1'b1;
        end
      end
    end

    if (bus_req.rd) begin
      if (bus_req.addr == STTX_CTRL_OFF) begin
        d.rd_data = ctrl_read;
      end
      for (int i = 0; i < 3; i++) begin
        if (bus_req.addr == STTX_DATA_OFF[i]) begin
          d.rd_data = {16'h0, q.data[i]};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{phase:   STTX_IDLE,
             en:      1'b0,
             cnt:     3'h0,
             data:    {STTX_DATA_RESET, STTX_DATA_RESET, STTX_DATA_RESET},
             filled:  3'h0,
             idx:     3'h0,
             rd_data: 32'h0};
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd_data;

  sequence s_key_first;
    bus_req.wr && bus_req.addr == STTX_KEY_FIRST_OFF &&
      bus_req.wdata[15:0] == STTX_KEY_FIRST_VAL;
  endsequence

  sequence s_bad_first;
    bus_req.wr && !(bus_req.addr == STTX_KEY_FIRST_OFF &&
      bus_req.wdata[15:0] == STTX_KEY_FIRST_VAL);
  endsequence

  sequence s_ctrl_write;
    bus_req.wr && bus_req.addr == STTX_CTRL_OFF;
  endsequence

  sequence s_key_second;
    bus_req.wr && bus_req.addr == STTX_KEY_SECOND_OFF &&
      bus_req.wdata[15:0] == STTX_KEY_SECOND_VAL;
  endsequence

  sequence s_bad_second;
    bus_req.wr && !(bus_req.addr == STTX_KEY_SECOND_OFF &&
      bus_req.wdata[15:0] == STTX_KEY_SECOND_VAL);
  endsequence

  chk_unlock_commit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_key_first ##1 s_ctrl_write ##1 s_key_second |=> key_commit)
    else $error("Full key sequence did not commit the control write.");

  chk_first_reject: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_bad_first ##1 s_ctrl_write ##1 s_key_second |=> !key_commit)
    else $error("Control write committed without the first key.");

  chk_second_reject: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_key_first ##1 s_ctrl_write ##1 s_bad_second |=> ##1 $stable(q.en) && $stable(q.cnt))
    else $error("Control changed without the second key.");

  chk_ctrl_update: assert property (@(posedge clk_sys) disable iff (!reset_n)
    key_commit && !key_val[STTX_RST_BIT] |=>
      q.en == $past(key_val[STTX_EN_BIT]) &&
      q.cnt == $past(key_val[STTX_CNT_MSB:STTX_CNT_LSB]))
    else $error("Committed control value not taken.");

  chk_soft_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
    key_commit && key_val[STTX_RST_BIT] |=>
      !q.en && q.cnt == 3'h0 && q.phase == STTX_IDLE && ctrl_read == 32'h0)
    else $error("Soft reset left control nonzero.");

  chk_start_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(q.phase == STTX_SEND) |-> $past(flags_ok && q.en))
    else $error("Transmission began before all bytes were written.");

  chk_state_field: assert property (@(posedge clk_sys) disable iff (!reset_n)
    bus_req.rd && bus_req.addr == STTX_CTRL_OFF |=>
      (rd_data[STTX_STATE_MSB:STTX_STATE_LSB] != 4'h0) == $past(q.phase == STTX_SEND))
    else $error("State field disagrees with transmission activity.");

  chk_idle_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.phase == STTX_IDLE |-> diagnostic_serial_out == STTX_IDLE_LEVEL)
    else $error("Serial line not at rest level while idle.");

  chk_byte_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fr_take |-> q.idx < nbytes ##1 q.idx == $past(q.idx) + 3'h1 || $past(key_commit))
    else $error("Byte index did not advance by one per packet.");

  chk_done_readback: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(q.phase == STTX_SEND) && !$past(key_commit) |->
      $past(q.idx) == $past(nbytes) && state_field == 4'h0)
    else $error("Transmission ended before all selected bytes.");


  // Read data is driven only in the cycle after a read strobe.
  chk_rd_idle_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !bus_req.rd |=> rd_data == 32'h0)
    else $error("Read data not zero outside its answer cycle.");

  // Each data register keeps what was written and answers reads with it.
  for (genvar g = 0; g < 3; g++) begin : g_data_chk
    chk_data_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
      bus_req.wr && bus_req.addr == STTX_DATA_OFF[g] |=>
        q.data[g] == $past(bus_req.wdata[15:0]) && q.filled[g])
      else $error("Data register write not stored.");

    chk_data_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      bus_req.rd && bus_req.addr == STTX_DATA_OFF[g] |=>
        rd_data == {16'h0, $past(q.data[g])})
      else $error("Data register read returned a wrong value.");
  end

  // The port only sends while enabled, and a disable stops it at once.
  chk_send_enabled: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.phase == STTX_SEND |-> q.en)
    else $error("Transmission active while the port is disabled.");

  chk_disable_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    key_commit && !key_val[STTX_EN_BIT] |=>
      q.phase == STTX_IDLE && diagnostic_serial_out == STTX_IDLE_LEVEL)
    else $error("Disable did not stop the port at once.");

  // A soft reset leaves the line at rest.
  chk_reset_line: assert property (@(posedge clk_sys) disable iff (!reset_n)
    key_commit && key_val[STTX_RST_BIT] |=> diagnostic_serial_out == STTX_IDLE_LEVEL)
    else $error("Soft reset left the line away from rest.");

  // A commit restarts the fill bookkeeping unless a data write lands with it.
  chk_commit_refill: assert property (@(posedge clk_sys) disable iff (!reset_n)
    key_commit && !bus_req.wr |=> q.filled == 3'h0 && q.idx == 3'h0)
    else $error("Commit did not restart the fill count.");

  chk_fill_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.phase == STTX_IDLE && !flags_ok |=> q.phase == STTX_IDLE)
    else $error("Transmission started with a selected register unwritten.");

  // The byte index never passes the selected count.
  chk_idx_bound: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.idx <= nbytes)
    else $error("Byte index beyond the selected count.");

  // A busy line always shows in the state field.
  chk_busy_state: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fr_busy |-> q.phase == STTX_SEND && state_field != 4'h0)
    else $error("Line busy while the state field reads idle.");

  // Once idle, the readback holds only the enable bit and the count, with every other bit zero.
  chk_idle_readback: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.phase == STTX_IDLE |->
      ctrl_read == {23'h0, 4'h0, q.cnt, 1'b0, q.en})
    else $error("Idle readback differs from the written control value.");

  // Every falling edge of the line follows a baud tick.
  chk_start_on_tick: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(diagnostic_serial_out) |-> $past(baud_tick))
    else $error("Line fell without a baud tick.");

  // Packets follow back to back while selected bytes remain.
  chk_no_gap: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fr_busy && baud_tick && !key_commit && q.idx < nbytes |=> fr_busy)
    else $error("Gap between packets of one transmission.");

endmodule // sttx_top

// >>> design/sttx_pkg.sv
package sttx_pkg;

  localparam logic [31:0]       STTX_KEY_FIRST_OFF  = 32'hFFFF0880;
  localparam logic [31:0]       STTX_CTRL_OFF       = 32'hFFFF0884;
  localparam logic [31:0]       STTX_KEY_SECOND_OFF = 32'hFFFF0888;
  localparam logic [2:0][31:0]  STTX_DATA_OFF       = {32'hFFFF0894, 32'hFFFF0890, 32'hFFFF088C};

  localparam logic [15:0]       STTX_KEY_FIRST_VAL  = 16'h0007;
  localparam logic [15:0]       STTX_KEY_SECOND_VAL = 16'h00B9;
  localparam logic [15:0]       STTX_DATA_RESET     = 16'h0000;
  localparam logic [15:0]       STTX_CTRL_RESET     = 16'h0000;

  localparam int unsigned       STTX_EN_BIT         = 0;
  localparam int unsigned       STTX_RST_BIT        = 1;
  localparam int unsigned       STTX_CNT_LSB        = 2;
  localparam int unsigned       STTX_CNT_MSB        = 4;
  localparam int unsigned       STTX_STATE_LSB      = 5;
  localparam int unsigned       STTX_STATE_MSB      = 8;

  localparam logic [2:0]        STTX_CNT_MAX        = 3'h5;
  localparam logic [2:0]        STTX_BYTES_MAX      = 3'h6;
  localparam logic [3:0]        STTX_FRAME_BITS     = 4'hC;
  localparam logic              STTX_IDLE_LEVEL     = 1'b1;
  localparam logic              STTX_START_LEVEL    = 1'b0;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sttx_bus_req_s;

  typedef enum logic {
    STTX_IDLE,
    STTX_SEND
  } sttx_phase_e;

endpackage

// >>> design/sttx_key_guard.sv
`timescale 1ns/1ps
module sttx_key_guard (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire sttx_pkg::sttx_bus_req_s bus_req,
  output logic                        key_commit,
  output logic [15:0]                 key_val
);
  import sttx_pkg::*;

  typedef struct packed {
    logic        armed;
    logic        pend;
    logic        commit;
    logic [15:0] val;
  } sttx_guard_state_s;

  sttx_guard_state_s q, d;
  logic              first_hit;
  logic              ctrl_hit;
  logic              second_hit;

  assign first_hit  = bus_req.addr == STTX_KEY_FIRST_OFF &&
                      bus_req.wdata[15:0] == STTX_KEY_FIRST_VAL;
  assign ctrl_hit   = bus_req.addr == STTX_CTRL_OFF;
  assign second_hit = bus_req.addr == STTX_KEY_SECOND_OFF &&
                      bus_req.wdata[15:0] == STTX_KEY_SECOND_VAL;

  // Every bus write breaks the sequence unless it is the expected next step.
  always_comb begin
    d        = q;
    d.commit = 1'b0;
    if (bus_req.wr) begin
      d.armed = first_hit;
      d.pend  = q.armed && ctrl_hit;
      if (q.armed && ctrl_hit) begin
        d.val = bus_req.wdata[15:0];
      end
      d.commit = q.pend && second_hit;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{armed: 1'b0, pend: 1'b0, commit: 1'b0, val: STTX_CTRL_RESET};
    end else begin
      q <= d;
    end
  end

  assign key_commit = q.commit;
  assign key_val    = q.val;

endmodule // sttx_key_guard

// >>> design/sttx_framer.sv
`timescale 1ns/1ps
module sttx_framer (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       baud_tick,
  input  wire logic       abort,
  input  wire logic       load_valid,
  input  wire logic [7:0] load_byte,
  output logic            busy,
  output logic            take,
  output logic            serial_out
);
  import sttx_pkg::*;

  typedef struct packed {
    logic [10:0] sr;
    logic [3:0]  left;
    logic        take;
    logic        out;
  } sttx_frame_state_s;

  sttx_frame_state_s q, d;

  always_comb begin
    d      = q;
    d.take = 1'b0;
    if (abort) begin
      d.sr   = '0;
      d.left = 4'h0;
      d.out  = STTX_IDLE_LEVEL;
    end else if (baud_tick) begin
      if (q.left > 4'h1) begin
        d.out  = q.sr[0];
        d.sr   = {1'b1, q.sr[10:1]};
        d.left = q.left - 4'h1;
      end else if (load_valid) begin
        d.out  = STTX_START_LEVEL;
        d.sr   = {2'b11, ^load_byte, load_byte};
        d.left = STTX_FRAME_BITS;
        d.take = 1'b1;
      end else begin
        d.out  = STTX_IDLE_LEVEL;
        d.left = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{sr: 11'h0, left: 4'h0, take: 1'b0, out: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign busy       = q.left != 4'h0;
  assign take       = q.take;
  assign serial_out = q.out;

  chk_frame_parity: assert property (@(posedge clk_sys) disable iff (!reset_n)
    q.take |-> (^q.sr[8:0] == 1'b0 && q.sr[10:9] == 2'b11 && !q.out))
    else $error("Loaded frame has bad parity or stop bits.");

  chk_tick_advance: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !baud_tick && !abort |=> $stable(q.out) && $stable(q.left))
    else $error("Serial output moved without a baud tick.");

endmodule // sttx_framer

// >>> dv/sttx_tester.sv
`timescale 1ns/1ps
module sttx_tester (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       baud_tick,
  input  wire logic       serial_in,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            rx_err,
  output logic            edge_fault
);
  int          bit_idx;
  logic [10:0] frame;
  logic        tick_q;
  logic        line_q;

  // Samples the line once per baud tick and rebuilds each packet.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_idx = 0;
      frame = '0;
      tick_q <= 1'b0;
      line_q <= 1'b1;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      rx_err <= 1'b0;
      edge_fault <= 1'b0;
    end else begin
      tick_q <= baud_tick;
      line_q <= serial_in;
      rx_valid <= 1'b0;
      if (line_q === 1'b1 && serial_in === 1'b0 && tick_q !== 1'b1) begin
        edge_fault <= 1'b1;
      end
      if (baud_tick === 1'b1) begin
        if (bit_idx == 0) begin
          if (serial_in === 1'b0) begin
            bit_idx = 1;
          end
        end else begin
          frame[bit_idx-1] = serial_in;
          bit_idx++;
          if (bit_idx == 12) begin
            rx_valid <= 1'b1;
            rx_byte <= frame[7:0];
            rx_err <= (^frame[8:0] !== 1'b0) || (frame[10:9] !== 2'b11);
            bit_idx = 0;
          end
        end
      end
    end
  end
endmodule // sttx_tester

// >>> dv/serial_test_tx_port_test.sv
`timescale 1ns/1ps
module serial_test_tx_port_test;
  import sttx_pkg::*;
  logic          clk_sys;
  logic          reset_n;
  sttx_bus_req_s bus_req;
  logic [31:0]   rd_data;
  logic          baud_tick;
  logic          diagnostic_serial_out;
  logic          rx_valid;
  logic [7:0]    rx_byte;
  logic          rx_err;
  logic          edge_fault;
  int            err_count;
  int            checked;
  int            cycles;
  int            tick_gap;
  int            n;
  logic [8:0]    rxq[$];
  logic [15:0]   dat[3];
  logic [15:0]   cv;
  logic [31:0]   v;

  sttx_top i_sttx_top (.clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req),
    .rd_data(rd_data), .baud_tick(baud_tick), .diagnostic_serial_out(diagnostic_serial_out));
  sttx_tester i_sttx_tester (.clk_sys(clk_sys), .reset_n(reset_n), .baud_tick(baud_tick),
    .serial_in(diagnostic_serial_out), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_err(rx_err), .edge_fault(edge_fault));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  // Baud ticks with random spacing, plus the run time limit.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 40000) begin
      err_count++;
      complete_run();
    end else begin
      baud_tick <= (tick_gap == 0);
      tick_gap <= (tick_gap == 0) ? $urandom_range(3, 0) : tick_gap - 1;
      if (rx_valid === 1'b1) rxq.push_back({rx_err, rx_byte});
    end
  end

  task automatic wr(logic [31:0] a, logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: {16'h0000, d}, wr: 1'b1, rd: 1'b0};
  endtask

  task automatic idle();
    @(posedge clk_sys);
    bus_req <= '{addr: 32'h0, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd(logic [31:0] a, output logic [31:0] q);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    idle();
    #1 q = rd_data;
  endtask

  task automatic rdchk(string w, logic [31:0] a, logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    check(w, e, q);
  endtask

  task automatic ctrl_wr(logic [15:0] d);
    wr(STTX_KEY_FIRST_OFF, STTX_KEY_FIRST_VAL);
    wr(STTX_CTRL_OFF, d);
    wr(STTX_KEY_SECOND_OFF, STTX_KEY_SECOND_VAL);
    repeat (3) idle();
  endtask

  task automatic bad_unlock(logic [15:0] k0, bit extra, logic [15:0] k1);
    wr(STTX_KEY_FIRST_OFF, k0);
    if (extra) wr(32'hFFFF0898, 16'h0000);
    wr(STTX_CTRL_OFF, 16'h0005);
    wr(STTX_KEY_SECOND_OFF, k1);
    repeat (3) idle();
    rdchk("ctrl locked", STTX_CTRL_OFF, 32'h0);
  endtask

  function automatic logic [8:0] exp_byte(int k);
    return {1'b0, dat[k/2][8*(k%2) +: 8]};
  endfunction

  task automatic wait_cyc(int c);
    repeat (c) idle();
  endtask

  initial begin
    bus_req = '0;
    baud_tick = 1'b0;
    reset_n = 1'b0;
    tick_gap = 0;
    err_count = 0;
    checked = 0;
    cycles = 0;
    void'($urandom(32'h77c5b7f1));
    wait_cyc(10);
    reset_n <= 1'b1;
    for (int i = 0; i < 3; i++) rdchk("data reset", STTX_DATA_OFF[i], 32'(STTX_DATA_RESET));
    rdchk("ctrl reset", STTX_CTRL_OFF, 32'(STTX_CTRL_RESET));
    rdchk("key read", STTX_KEY_FIRST_OFF, 32'h0);
    rdchk("unmapped read", 32'hFFFF0898, 32'h0);
    bad_unlock(16'h0006, 1'b0, STTX_KEY_SECOND_VAL);
    bad_unlock(STTX_KEY_FIRST_VAL, 1'b1, STTX_KEY_SECOND_VAL);
    bad_unlock(STTX_KEY_FIRST_VAL, 1'b0, 16'h00B8);
    for (int c = 0; c < 6; c++) begin
      cv = {11'h000, 3'(c), 2'b01};
      ctrl_wr(cv);
      n = c + 1;
      for (int i = 0; i < (n + 1) / 2; i++) begin
        if (i == (n + 1) / 2 - 1) begin
          wait_cyc(30);
          check("bytes before fill", 32'h0, rxq.size());
        end
        dat[i] = 16'($urandom);
        wr(STTX_DATA_OFF[i], dat[i]);
      end
      idle();
      rd(STTX_CTRL_OFF, v);
      check("state busy", 32'h1, 32'(v[8:5] != 4'h0));
      for (int k = 0; k < 2000; k++) begin
        rd(STTX_CTRL_OFF, v);
        if (v === {16'h0, cv}) break;
      end
      check("ctrl done", {16'h0, cv}, v);
      check("byte count", n, rxq.size());
      for (int k = 0; k < n && k < rxq.size(); k++) check("byte", exp_byte(k), rxq[k]);
      check("idle line", 32'(STTX_IDLE_LEVEL), diagnostic_serial_out);
      for (int i = 0; i < (n + 1) / 2; i++) rdchk("data rd", STTX_DATA_OFF[i], dat[i]);
      rxq.delete();
    end
    ctrl_wr(16'h0015);
    for (int i = 0; i < 3; i++) wr(STTX_DATA_OFF[i], dat[i]);
    idle();
    for (int k = 0; k < 3000 && rxq.size() < 2; k++) @(posedge clk_sys);
    ctrl_wr(16'h0002);
    rdchk("soft reset", STTX_CTRL_OFF, 32'h0);
    check("line after reset", 32'h1, diagnostic_serial_out);
    rdchk("data kept", STTX_DATA_OFF[0], dat[0]);
    wait_cyc(80);
    ctrl_wr(16'h0001);
    wr(STTX_DATA_OFF[0], dat[0]);
    idle();
    for (int k = 0; k < 100 && diagnostic_serial_out !== 1'b0; k++) @(posedge clk_sys);
    wait_cyc(6);
    ctrl_wr(16'h0000);
    n = 0;
    for (int k = 0; k < 80; k++) begin
      @(posedge clk_sys);
      if (diagnostic_serial_out !== 1'b1) n++;
    end
    check("disabled low cycles", 32'h0, n);
    check("tick aligned edges", 32'h0, edge_fault);
    complete_run();
  end
endmodule // serial_test_tx_port_test
